// ---- rtl/spvp_pkg.sv ----
/*
  spvp_pkg: constants, types and state record of the serial program/verify
  port. Assumes a single 100 MHz core clock; everything else is sampled.
*/
`default_nettype none

package spvp_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;        // core clock period
  localparam int ERASE_TIME_US = 10;        // self-timed bulk erase length
  localparam int ERASE_CYCLES  = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [4:0] CMD_BITS    = 5'h04; // command code clocks
  localparam logic [4:0] FRAME_LAST  = 5'h13; // index of the 20th bit
  localparam logic [4:0] OUT_FIRST   = 5'h0c; // first output bit of operand
  localparam int         SYNC_W      = 3;     // sclk, data, voltage pin

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [3:0] CMD_CORE    = 4'h0; // core instruction
  localparam logic [3:0] CMD_LATCH   = 4'h2; // shift out table latch
  localparam logic [3:0] CMD_RD      = 4'h8; // table read
  localparam logic [3:0] CMD_RD_PI   = 4'h9; // read, post-increment
  localparam logic [3:0] CMD_RD_PD   = 4'ha; // read, post-decrement
  localparam logic [3:0] CMD_RD_PRE  = 4'hb; // read, pre-increment
  localparam logic [3:0] CMD_WR      = 4'hc; // table write
  localparam logic [3:0] CMD_WR_PI2  = 4'hd; // write, post-increment by 2
  localparam logic [3:0] CMD_WR_PD2  = 4'he; // write, post-decrement by 2
  localparam logic [3:0] CMD_WR_PROG = 4'hf; // write, start programming

  // ************************************************************
  // addresses and erase options
  // ************************************************************
  localparam logic [21:0] ADDR_ERASE_CTRL = 22'h3c0004; // erase option target
  localparam logic [21:0] ADDR_PROTECT    = 22'h300008; // protection byte
  localparam logic [11:0] SFR_PTR_UPPER   = 12'hff8;    // pointer bits 21:16
  localparam logic [11:0] SFR_PTR_HIGH    = 12'hff7;    // pointer bits 15:8
  localparam logic [11:0] SFR_PTR_LOW     = 12'hff6;    // pointer bits 7:0
  localparam logic [7:0]  ERASE_DATA   = 8'h81;
  localparam logic [7:0]  ERASE_BOOT   = 8'h83;
  localparam logic [7:0]  ERASE_PANEL1 = 8'h88;
  localparam logic [7:0]  ERASE_PANEL2 = 8'h89;
  localparam logic [7:0]  ERASE_PANEL3 = 8'h8a;
  localparam logic [4:0]  PROT_RESET   = 5'h1f; // all regions unprotected

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    SPVP_CMD,      // shifting the command code
    SPVP_OPERAND,  // shifting the operand
    SPVP_ERASE     // self-timed erase, serial clocks ignored
  } spvp_state_t;

  // memory request towards the array controller
  typedef struct packed {
    logic        rd;     // read pulse, data expected next cycle
    logic        wr;     // write pulse
    logic [21:0] addr;
    logic [7:0]  wdata;
  } spvp_mem_t;

  // whole state of the port
  typedef struct packed {
    spvp_state_t st;
    logic        busy;       // erase running, mirrors the erase state
    logic        active;     // program/verify mode entered
    logic        pv_d;       // previous voltage pin level
    logic        sclk_d;     // previous serial clock level
    logic [4:0]  bit_cnt;    // bits completed in this frame
    logic [3:0]  cmd;
    logic [15:0] shreg;
    logic [21:0] ptr;
    logic [7:0]  latch;
    logic        rd_wait;
    logic        rd_prot;
    logic        erase_pend;
    logic [7:0]  erase_opt;
    logic [15:0] erase_cnt;
    logic        erase_go;
    logic [4:0]  prot;       // 1 = unprotected, per region
    logic        sdo;
    logic        oe;
    logic [15:0] core_instr;
    logic        core_vld;
    logic        prog_start;
    spvp_mem_t   mem;
  } spvp_state_rec_t;

endpackage

`default_nettype wire

// ---- rtl/spvp_sync.sv ----
/*
  spvp_sync: two-flop synchronisers for the asynchronous pins.
  Assumes the pins are slow compared to the core clock.
*/
`default_nettype none

module spvp_sync
(
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic [spvp_pkg::SYNC_W-1:0] pins,
  output var  logic [spvp_pkg::SYNC_W-1:0] synced
);

  // ************************************************************
  // one synchroniser per pin
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < spvp_pkg::SYNC_W; gi++)
    begin : g_bit
      logic meta_r; // first stage, read only by the second
      // two stages; the first may go metastable
      always_ff @(posedge clock)
      begin
        if (!nrst)
        begin
          meta_r     <= 1'b0;
          synced[gi] <= 1'b0;
        end
        else
        begin
          meta_r     <= pins[gi];
          synced[gi] <= meta_r;
        end
      end
    end
  endgenerate

endmodule // spvp_sync

`default_nettype wire

// ---- rtl/spvp_port.sv ----
/*
  spvp_port: serial program/verify command interpreter.
  Assumes the programmer clocks slower than a quarter of the core clock,
  a core that executes handed-over instructions and writes pointer SFRs,
  and an array controller answering reads one cycle later.
*/
//
// Functional notes
// - serial clock input, data line bidirectional
// - drive after rising edge, sample on falling
// - all fields shifted least significant bit first
// - twenty-bit frame: command then sixteen-bit operand
// - four clocks deliver the command code
// - 0000 core instruction, 0010 shifts latch out
// - decode read variants and write post-increment two
// - 1110 post-decrement two, 1111 starts programming
// - operand: sixteen in, or eight in eight out
// - core instruction operand handed to the core
// - erased cells read as ones
// - unused reserved configuration bits read zero
// - erase by writing option to erase address
// - decode erase options, panels two/three large only
// - bulk erase clears matching code protection
// - erase starts fourth falling edge, commands stall
// - only bulk erase lifts code protection
// - pointer from three byte SFRs
`default_nettype none

module spvp_port
#(
  parameter bit LARGE_VARIANT = 1'b1 // panels two and three present
)
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               sclk_pin,
  input  wire logic               serial_io_line_in,
  output var  logic               serial_io_line_out,
  output var  logic               serial_io_line_oe,
  input  wire logic               program_voltage_pin,
  input  wire logic               sfr_wr,
  input  wire logic [11:0]        sfr_addr,
  input  wire logic [7:0]         sfr_wdata,
  input  wire logic [7:0]         mem_rdata,
  output var  spvp_pkg::spvp_mem_t mem_req,
  output var  logic [15:0]        core_instr,
  output var  logic               core_instr_valid,
  output var  logic               prog_start,
  output var  logic               erase_start,
  output var  logic [7:0]         erase_option,
  output var  logic               erase_busy,
  output var  logic [4:0]         protect_state,
  output var  logic [21:0]        table_pointer,
  output var  logic [7:0]         table_latch,
  output var  logic               mode_active
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [spvp_pkg::SYNC_W-1:0] sync_w; // {pv, data, sclk}

  spvp_sync u_sync
  (
    .clock  (clock),
    .nrst   (nrst),
    .pins   ({program_voltage_pin, serial_io_line_in, sclk_pin}),
    .synced (sync_w)
  );

  spvp_pkg::spvp_state_rec_t r;   // registered state
  spvp_pkg::spvp_state_rec_t n;   // next state
  logic                      rise; // serial clock rising edge
  logic                      fall; // serial clock falling edge
  logic                      din;  // sampled data level
  logic                      pv;   // voltage pin at entry level

  assign din  = sync_w[1];
  assign pv   = sync_w[2];
  assign rise = sync_w[0] & ~r.sclk_d;
  assign fall = ~sync_w[0] & r.sclk_d;

  // read-type commands carry eight output bits
  function automatic logic out_half(input logic [3:0] c);
    out_half = (c == spvp_pkg::CMD_LATCH) || (c[3:2] == 2'b10);
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    n            = r;
    n.sclk_d     = sync_w[0];
    n.pv_d       = pv;
    n.core_vld   = 1'b0;
    n.prog_start = 1'b0;
    n.erase_go   = 1'b0;
    n.mem.rd     = 1'b0;
    n.mem.wr     = 1'b0;
    n.rd_wait    = r.mem.rd; // array answers the cycle after the request

    // pointer bytes written by executed core instructions
    if (sfr_wr)
    begin
      case (sfr_addr)
        spvp_pkg::SFR_PTR_UPPER: n.ptr[21:16] = sfr_wdata[5:0];
        spvp_pkg::SFR_PTR_HIGH:  n.ptr[15:8]  = sfr_wdata;
        spvp_pkg::SFR_PTR_LOW:   n.ptr[7:0]   = sfr_wdata;
        default:                 n.ptr        = n.ptr;
      endcase
    end

    // read data lands in the latch one cycle after the request
    if (r.rd_wait)
      n.latch = r.rd_prot ? {3'h0, r.prot} : mem_rdata;

    // entry: lines low when the voltage pin reaches entry level
    if (pv && !r.pv_d && !sync_w[0] && !din)
      n.active = 1'b1;
    if (!pv)
    begin
      // leaving the mode drops any frame in flight
      n.active   = 1'b0;
      n.st       = spvp_pkg::SPVP_CMD;
      n.bit_cnt  = 5'h00;
      n.oe       = 1'b0;
      n.sdo      = 1'b0;
      n.erase_pend = 1'b0;
    end
    else if (r.active)
    begin
      case (r.st)
        spvp_pkg::SPVP_CMD:
        begin
          if (fall)
          begin
            n.cmd     = {din, r.cmd[3:1]};
            n.bit_cnt = r.bit_cnt + 5'h01;
            if (r.bit_cnt == spvp_pkg::CMD_BITS - 5'h01)
            begin
              if (r.erase_pend)
              begin
                // erase begins on this edge; the frame is abandoned
                n.erase_pend = 1'b0;
                n.erase_go   = 1'b1;
                n.erase_cnt  = 16'(spvp_pkg::ERASE_CYCLES - 1);
                n.st         = spvp_pkg::SPVP_ERASE;
                n.bit_cnt    = 5'h00;
                case (r.erase_opt)
                  spvp_pkg::ERASE_BOOT:   n.prot[0] = 1'b1;
                  spvp_pkg::ERASE_PANEL1: n.prot[1] = 1'b1;
                  spvp_pkg::ERASE_PANEL2: n.prot[2] = 1'b1;
                  spvp_pkg::ERASE_PANEL3: n.prot[3] = 1'b1;
                  default:                n.prot[4] = 1'b1;
                endcase
              end
              else
              begin
                n.st = spvp_pkg::SPVP_OPERAND;
                if (n.cmd[3:2] == 2'b10)
                begin
                  // pre-increment moves the pointer before the read
                  n.mem.addr = (n.cmd == spvp_pkg::CMD_RD_PRE) ? r.ptr + 22'h1 : r.ptr;
                  n.mem.rd   = 1'b1;
                  n.rd_prot  = (n.mem.addr == spvp_pkg::ADDR_PROTECT);
                  case (n.cmd)
                    spvp_pkg::CMD_RD_PI:  n.ptr = r.ptr + 22'h1;
                    spvp_pkg::CMD_RD_PD:  n.ptr = r.ptr - 22'h1;
                    spvp_pkg::CMD_RD_PRE: n.ptr = r.ptr + 22'h1;
                    default:              n.ptr = r.ptr;
                  endcase
                end
              end
            end
          end
        end

        spvp_pkg::SPVP_OPERAND:
        begin
          // output half: drive after the rising edge
          if (rise && out_half(r.cmd) && r.bit_cnt >= spvp_pkg::OUT_FIRST)
          begin
            n.sdo = r.latch[3'(r.bit_cnt - spvp_pkg::OUT_FIRST)];
            n.oe  = 1'b1;
          end
          if (fall)
          begin
            n.shreg   = {din, r.shreg[15:1]};
            n.bit_cnt = r.bit_cnt + 5'h01;
            if (r.bit_cnt == spvp_pkg::FRAME_LAST)
            begin
              n.st      = spvp_pkg::SPVP_CMD;
              n.bit_cnt = 5'h00;
              n.oe      = 1'b0;
              n.sdo     = 1'b0;
              if (r.cmd == spvp_pkg::CMD_CORE)
              begin
                n.core_instr = n.shreg;
                n.core_vld   = 1'b1;
              end
              else if (r.cmd[3:2] == 2'b11)
              begin
                // table write: low operand byte is the data
                if (r.ptr == spvp_pkg::ADDR_ERASE_CTRL)
                begin
                  case (n.shreg[7:0])
                    spvp_pkg::ERASE_DATA, spvp_pkg::ERASE_BOOT, spvp_pkg::ERASE_PANEL1:
                      n.erase_pend = 1'b1;
                    spvp_pkg::ERASE_PANEL2, spvp_pkg::ERASE_PANEL3:
                      n.erase_pend = LARGE_VARIANT;
                    default:
                      n.erase_pend = 1'b0;
                  endcase
                  n.erase_opt = n.shreg[7:0];
                end
                else if (r.ptr == spvp_pkg::ADDR_PROTECT)
                  n.prot = r.prot & n.shreg[4:0];
                else
                begin
                  n.mem.wr    = 1'b1;
                  n.mem.addr  = r.ptr;
                  n.mem.wdata = n.shreg[7:0];
                end
                case (r.cmd)
                  spvp_pkg::CMD_WR_PI2: n.ptr = r.ptr + 22'h2;
                  spvp_pkg::CMD_WR_PD2: n.ptr = r.ptr - 22'h2;
                  default:              n.ptr = r.ptr;
                endcase
                n.prog_start = (r.cmd == spvp_pkg::CMD_WR_PROG);
              end
            end
          end
        end

        spvp_pkg::SPVP_ERASE:
        begin
          // serial clocks are ignored until the timer runs out
          if (r.erase_cnt == 16'h0000)
            n.st = spvp_pkg::SPVP_CMD;
          else
            n.erase_cnt = r.erase_cnt - 16'h0001;
        end

        default:
          n.st = spvp_pkg::SPVP_CMD;
      endcase
    end
    // registered copy so the busy output leaves a flop directly
    n.busy = (n.st == spvp_pkg::SPVP_ERASE);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      r      <= '0;
      r.prot <= spvp_pkg::PROT_RESET;
    end
    else
      r <= n;
  end

  // outputs straight from the state register
  assign serial_io_line_out = r.sdo;
  assign serial_io_line_oe  = r.oe;
  assign mem_req            = r.mem;
  assign core_instr         = r.core_instr;
  assign core_instr_valid   = r.core_vld;
  assign prog_start         = r.prog_start;
  assign erase_start        = r.erase_go;
  assign erase_option       = r.erase_opt;
  assign erase_busy         = r.busy;
  assign protect_state      = r.prot;
  assign table_pointer      = r.ptr;
  assign table_latch        = r.latch;
  assign mode_active        = r.active;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_frame_len;
    @(posedge clock) disable iff (!nrst) r.bit_cnt <= spvp_pkg::FRAME_LAST;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame longer than 20 bits");

  property p_cmd_four;
    @(posedge clock) disable iff (!nrst)
      (r.active && pv && r.st == spvp_pkg::SPVP_CMD && fall && r.bit_cnt == 5'h03
       && !r.erase_pend) |=> (r.st == spvp_pkg::SPVP_OPERAND && r.bit_cnt == 5'h04);
  endproperty
  a_cmd_four: assert property (p_cmd_four) else $error("command not taken after four clocks");

  property p_oe_window;
    @(posedge clock) disable iff (!nrst)
      r.oe |-> (r.st == spvp_pkg::SPVP_OPERAND && out_half(r.cmd)
                && r.bit_cnt >= spvp_pkg::OUT_FIRST);
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("data line driven outside output half");

  property p_drive_on_rise;
    @(posedge clock) disable iff (!nrst)
      ($rose(r.oe) || (r.oe && $changed(r.sdo))) |-> $past(rise);
  endproperty
  a_drive_on_rise: assert property (p_drive_on_rise) else $error("output changed off rising edge");

  property p_core_hand;
    @(posedge clock) disable iff (!nrst)
      r.core_vld |-> ($past(r.cmd) == spvp_pkg::CMD_CORE && $past(r.bit_cnt) == 5'h13);
  endproperty
  a_core_hand: assert property (p_core_hand) else $error("core instruction without frame");

  property p_wr_inc2;
    @(posedge clock) disable iff (!nrst)
      (r.active && pv && r.st == spvp_pkg::SPVP_OPERAND && fall && !sfr_wr
       && r.bit_cnt == 5'h13 && r.cmd == spvp_pkg::CMD_WR_PI2) |=> r.ptr == $past(r.ptr) + 22'h2;
  endproperty
  a_wr_inc2: assert property (p_wr_inc2) else $error("pointer not advanced by two");

  property p_prog;
    @(posedge clock) disable iff (!nrst)
      (r.active && pv && r.st == spvp_pkg::SPVP_OPERAND && fall
       && r.bit_cnt == 5'h13 && r.cmd == spvp_pkg::CMD_WR_PROG) |=> prog_start;
  endproperty
  a_prog: assert property (p_prog) else $error("programming not started");

  property p_erase_stall;
    @(posedge clock) disable iff (!nrst)
      (r.st == spvp_pkg::SPVP_ERASE && pv) |=> (r.bit_cnt == 5'h00 && !r.oe && !r.core_vld);
  endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("serial activity during erase");

  property p_prot_lift;
    @(posedge clock) disable iff (!nrst)
      (|(r.prot & ~$past(r.prot))) |-> $past(r.erase_pend) && r.erase_go;
  endproperty
  a_prot_lift: assert property (p_prot_lift) else $error("protection lifted without erase");

  c_core:  cover property (@(posedge clock) disable iff (!nrst) r.core_vld);
  c_read:  cover property (@(posedge clock) disable iff (!nrst) $fell(r.oe));
  c_erase: cover property (@(posedge clock) disable iff (!nrst) $fell(erase_busy));

endmodule // spvp_port

`default_nettype wire

// ---- verification/spvp_prog_model.sv ----
/*
  spvp_prog_model: behavioural programmer on the far side of the serial port.
  Assumes the bench resolves the data line from the device enable alone.
*/
`default_nettype none

module spvp_prog_model
(
  input  wire logic clk,    // bench clock, paces every pin change
  input  wire logic line,   // resolved data line level
  output var  logic sclk,   // serial clock, still between frames
  output var  logic d,      // level offered on the data line
  output var  logic en,     // programmer drives the data line
  output var  logic vpin    // high = pin at entry level
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: lines low, voltage pin down
  initial
  begin
    sclk = 1'b0;
    d    = 1'b0;
    en   = 1'b1;
    vpin = 1'b0;
  end

  // ************************************************************
  // mode entry and one twenty-bit frame
  // ************************************************************
  task automatic enter();
    sclk <= 1'b0;
    d    <= 1'b0;
    repeat (10) @(posedge clk);
    vpin <= 1'b1;                                 // lines low first, then raise
  endtask

  // eight core cycles per serial clock; hold stretches the fourth high phase
  task automatic frame(input logic [3:0] cmd, input logic [15:0] opnd, input int hold,
                       output logic [7:0] rd);
    logic [19:0] bits;
    logic        rd_frame;
    logic        drv;
    bits     = {opnd, cmd};                       // command code rides first
    rd_frame = (cmd == 4'h2) || (cmd[3:2] == 2'b10);
    rd       = 8'h00;
    drv      = 1'b1;
    @(posedge clk);
    for (int i = 0; i < 20; i++)
    begin
      sclk <= 1'b1;                               // clock input of the port
      @(posedge clk);
      drv = !(rd_frame && i >= 12);
      en  <= drv;                                 // release for the output half
      d   <= drv ? bits[i] : ~d;                  // lsb first; released line wanders
      repeat (3) @(posedge clk);
      if (i == 3)
        repeat (hold) @(posedge clk);             // program pulse on the fourth clock
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
      if (!drv)
        rd[i - 12] = line;                        // device bit settled after the fall
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);                    // let the device let go before driving
    en <= 1'b1;
    d  <= 1'b0;                                   // held low between frames and in erase
  endtask

endmodule // spvp_prog_model

`default_nettype wire

// ---- verification/spvp_port_test.sv ----
/*
  spvp_port_test: self-checking bench for the serial program/verify port.
  Assumes spvp_prog_model as programmer and a 100 MHz core clock.
*/
`default_nettype none

module spvp_port_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // stimulus, outputs and the resolved data line
  // ************************************************************
  logic                clock     = 1'b0;
  logic                nrst      = 1'b0;
  logic                sfr_wr    = 1'b0;
  logic [11:0]         sfr_addr  = 12'h000;
  logic [7:0]          sfr_wdata = 8'h00;
  logic [7:0]          mem_rdata = 8'h00;
  logic                io_out, io_oe, core_vld, prog_go, erase_go, erase_busy, mode_on;
  logic [15:0]         core_instr;
  logic [7:0]          erase_opt, latch, rd, wr_addr, wr_data;
  logic [4:0]          prot;
  logic [4:0]          exp_prot  = 5'h00;
  logic [21:0]         ptr;
  spvp_pkg::spvp_mem_t mem_req;
  logic                sclk, pd, pen, vpin;
  wire  logic          line;
  int                  mismatches, checks_done, n_core, n_prog, n_erase, n_wr, busy_len, busy_base;
  // table steps: command, address touched, pointer after
  logic [3:0] cm [9] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'h2, 4'hc, 4'hd, 4'he, 4'hf};
  logic [7:0] ad [9] = '{8'h10, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h13, 8'h11};
  logic [7:0] pt [9] = '{8'h10, 8'h11, 8'h10, 8'h11, 8'h11, 8'h11, 8'h13, 8'h11, 8'h11};
  logic [7:0] ops [5] = '{8'h81, 8'h83, 8'h88, 8'h89, 8'h8a};
  int         pb  [5] = '{4, 0, 1, 2, 3};
  // core steps of a panel-two row erase: permit, unlock, start, wait, clear
  logic [15:0] unl [8] = '{16'h84a6, 16'h0e55, 16'h6ea7, 16'h0eaa,
                           16'h6ea7, 16'h82a6, 16'h0000, 16'h94a6};

  assign line = io_oe ? io_out : pd;              // device wins only while it drives

  always #5 clock = ~clock;

  spvp_port #(.LARGE_VARIANT(1'b1)) dut
  (
    .clock(clock), .nrst(nrst), .sclk_pin(sclk), .serial_io_line_in(line),
    .serial_io_line_out(io_out), .serial_io_line_oe(io_oe), .program_voltage_pin(vpin),
    .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .core_instr(core_instr), .core_instr_valid(core_vld),
    .prog_start(prog_go), .erase_start(erase_go), .erase_option(erase_opt),
    .erase_busy(erase_busy), .protect_state(prot), .table_pointer(ptr),
    .table_latch(latch), .mode_active(mode_on)
  );

  spvp_prog_model prog (.clk(clock), .line(line), .sclk(sclk), .d(pd), .en(pen), .vpin(vpin));

  // ************************************************************
  // array model and event counters
  // ************************************************************
  always @(posedge clock)
  begin
    if (mem_req.rd)
      mem_rdata <= mem_req.addr[7:0] ^ 8'h5a;     // pattern from the low address byte
    if (mem_req.wr)
    begin
      n_wr    <= n_wr + 1;
      wr_addr <= mem_req.addr[7:0];
      wr_data <= mem_req.wdata;
    end
    n_core   <= n_core + int'(core_vld);
    n_prog   <= n_prog + int'(prog_go);
    n_erase  <= n_erase + int'(erase_go);
    busy_len <= busy_len + int'(erase_busy);
    if (io_oe === 1'b1 && pen === 1'b1)           // both driving the line
    begin
      mismatches++;
      $display("Error at %0t: data line contention", $realtime);
    end
  end

  // ************************************************************
  // access tasks and comparison
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $realtime, got, exp);
    end
  endtask

  // one frame, then a quiet gap before the next
  task automatic fr(input logic [3:0] cmd, input logic [15:0] op);
    prog.frame(cmd, op, 0, rd);
    repeat (10) @(posedge clock);
  endtask

  // core loads the pointer through its three byte registers
  task automatic sfr_set(input logic [21:0] p);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      sfr_wr    <= 1'b1;
      sfr_addr  <= spvp_pkg::SFR_PTR_UPPER - 12'(k);
      sfr_wdata <= 8'(p >> (16 - 8 * k));
    end
    @(posedge clock);
    sfr_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic print_verdict();
    $display("Checks done %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog: whole run needs about 100 us
  initial
  begin
    #300us;
    mismatches++;
    $display("Error at %0t: watchdog expired", $realtime);
    print_verdict();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin
    repeat (3) @(posedge clock);
    chk(prot, 24'h1f);                            // all regions open out of reset
    chk(mode_on, 24'h0);
    nrst <= 1'b1;
    repeat (5) @(posedge clock);
    fr(spvp_pkg::CMD_CORE, 16'h1234);
    chk(n_core, 24'h0);                           // clocks ignored before entry
    prog.enter();
    repeat (10) @(posedge clock);
    chk(mode_on, 24'h1);
    fr(spvp_pkg::CMD_CORE, 16'h0e3c);
    chk(core_instr, 24'h0e3c);
    chk(n_core, 24'h1);
    sfr_set(22'h000010);
    chk(ptr, 24'h10);
    for (int i = 0; i < 9; i++)
    begin
      fr(cm[i], {8'ha5, 8'h30 + 8'(i)});
      chk(ptr, pt[i]);
      if (cm[i][2])
        chk({wr_addr, wr_data}, {ad[i], 8'h30 + 8'(i)});
      else
      begin
        chk(rd, ad[i] ^ 8'h5a);
        chk(latch, ad[i] ^ 8'h5a);
      end
    end
    chk(n_prog, 24'h1);
    prog.frame(spvp_pkg::CMD_CORE, 16'h0000, 50, rd); // nop, long fourth clock
    repeat (10) @(posedge clock);
    chk(n_core, 24'h2);
    sfr_set(spvp_pkg::ADDR_PROTECT);
    fr(spvp_pkg::CMD_WR, 16'h0000);               // close every region
    fr(spvp_pkg::CMD_WR, 16'h00ff);
    chk(prot, 24'h00);
    fr(spvp_pkg::CMD_RD, 16'h0000);
    chk(rd, 8'h00);
    chk(n_wr, 24'h4);                             // protection byte stays local
    sfr_set(spvp_pkg::ADDR_ERASE_CTRL);
    for (int i = 0; i < 5; i++)                   // one erase per option, each started by a nop
    begin
      fr(spvp_pkg::CMD_WR, {8'h00, ops[i]});
      busy_base = busy_len;
      fr(spvp_pkg::CMD_CORE, 16'h0000);           // nop carries the start clock
      for (int w = 0; w < 1200 && erase_busy !== 1'b0; w++)
        @(posedge clock);
      exp_prot = exp_prot | (5'h01 << pb[i]);
      chk(erase_opt, ops[i]);
      chk(prot, exp_prot);
      chk(busy_len - busy_base, spvp_pkg::ERASE_CYCLES);
      chk(n_erase, i + 1);
    end
    chk(n_core, 24'h2);                           // clocks during erase start nothing
    chk(n_wr, 24'h4);
    sfr_set(22'h3c0006);                          // panel write mode address
    fr(spvp_pkg::CMD_WR, 16'h0000);               // single-panel writes
    chk({wr_addr, wr_data}, 24'h0600);
    sfr_set(22'h200000);                          // first block of panel two
    chk(ptr, 24'h200000);
    for (int i = 0; i < 8; i++)
    begin
      fr(spvp_pkg::CMD_CORE, unl[i]);
      chk(core_instr, unl[i]);
    end
    chk(n_core, 24'ha);
    chk(n_wr, 24'h5);
    print_verdict();
  end

endmodule // spvp_port_test

`default_nettype wire
